// ==== core/mbeu_core.sv ====
`timescale 1ns/1ns
// Operation
// - integer multiplies write the 16-bit product to r1:r0, set Z and C, two cycles.
// - fractional multiplies shift the product left one bit first, Z and C, two cycles.
// - register test keeps the value, updates Z, N, V, one cycle.
// - clear gives zero with Z, N, V; set-all loads 0xff, no flags; one cycle.
// - jumps: relative pc+k+1, pointer, extension:pointer two cycles; absolute three.
// - calls reach the jump targets; relative and pointer four cycles, absolute five.
// - compare-skip advances pc by two or three when equal; 1/2/3 cycles, no flags.
// - compares subtract without storing, update Z, N, V, C, H in one cycle.
// - register bit skips skip on bit clear or set; 1/2/3 cycles, no flags.
// - peripheral bit skips skip on bit set or clear; 1/2/3 cycles, no flags.
// - flag branches add k+1 on chosen flag set or clear; 1 or 2 cycles.
// - equal and not-equal branches test Z one or zero; 1 or 2 cycles.
// - carry set, lower on C one; carry clear, same-or-higher on C zero.
// - minus and plus branches test N one or zero; 1 or 2 cycles.
// - signed ge taken when N xor V is zero, lt when one.
// - half-carry branches test H one or zero, no flag change.
// - transfer-bit branches test T one or zero, no flag change.
module mbeu_core
  import mbeu_pkg::*;
#(
  parameter int PC_W = PC_WIDTH,
  parameter int STACK_DEPTH = STACK_DEPTH_DEF
)(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  // axi4-lite write address and data
  input wire logic [AXI_AW-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  // axi4-lite write response
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // axi4-lite read
  input wire logic [AXI_AW-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // execution status
  output logic O_BUSY
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  generate
    if (PC_W < 16 || PC_W > 24 || STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH)
    begin : g_bad_param
      $error("mbeu_core: PC_W must be 16..24 and STACK_DEPTH a power of two");
    end
  endgenerate

  mbeu_state_t state;
  mbeu_op_t op;
  logic [2:0] cnt;
  logic [31:0] src;
  logic [KOFF_W-1:0] koff;
  logic [PC_W-1:0] jaddr;
  logic [23:0] ptr;
  logic [PC_W-1:0] pc;
  logic [7:0] flags;
  logic [7:0] rd_result;
  logic [15:0] r1r0;
  logic [SP_W-1:0] sp;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [AXI_AW-1:0] aw_addr;
  logic aw_hold;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_hold;
  logic wr_fire;
  logic wr_map;
  logic start;
  logic commit;
  logic [31:0] rd_mux;
  logic rd_map;
  logic [15:0] mul_p;
  logic mul_c;
  logic [7:0] rd;
  logic [7:0] rr;
  logic [8:0] diff;
  logic [7:0] brw;
  logic cond;
  logic is_branch;
  logic is_skip;
  logic push;
  logic pop;
  logic [2:0] cycles;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] ret_addr;
  logic [PC_W-1:0] next_pc;
  logic [7:0] next_flags;
  logic [7:0] next_rd;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        m[8*b +: 8] = data[8*b +: 8];
    end
    return m;
  endfunction

  assign rd = src[SRC_RD_LSB +: 8];
  assign rr = (op == cmp_imm_op) ? src[SRC_RR_LSB +: 8] : src[SRC_RR_LSB +: 8];
  assign pc_inc = pc + PC_W'(1);
  assign O_AWREADY = ~aw_hold & ~O_BVALID;
  assign O_WREADY = ~w_hold & ~O_BVALID;
  assign O_ARREADY = ~O_RVALID;
  assign wr_fire = aw_hold & w_hold & ~O_BVALID;
  assign start = wr_fire & (aw_addr == ADDR_CMD) & ~O_BUSY & w_strb[0];
  assign commit = (state == st_run) && (cnt == cycles);
  assign O_BUSY = (state == st_run);

  // write channels are captured independently, so either may arrive first
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_hold <= 1'b1;
        aw_addr <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_hold <= 1'b1;
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end
      if (wr_fire)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (O_BVALID && I_BREADY)
        O_BVALID <= 1'b0;
    end
  end

  // writable map; results and status are read-only
  always_comb
  begin
    case (aw_addr)
      ADDR_CMD, ADDR_SRC, ADDR_KOFF, ADDR_JADDR, ADDR_PTR, ADDR_PC, ADDR_FLAGS, ADDR_SP: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  // operand registers; writes while busy are dropped so a running op sees stable inputs
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      op <= reg_test_op;
      src <= 32'h0000_0000;
      koff <= '0;
      jaddr <= '0;
      ptr <= 24'h00_0000;
    end
    else if (wr_fire && !O_BUSY)
    begin
      case (aw_addr)
        ADDR_CMD: if (w_strb[0]) op <= mbeu_op_t'(w_data[5:0]);
        ADDR_SRC: src <= merge(src, w_data, w_strb);
        ADDR_KOFF: koff <= KOFF_W'(merge({20'h00000, koff}, w_data, w_strb));
        ADDR_JADDR: jaddr <= PC_W'(merge(32'(jaddr), w_data, w_strb));
        ADDR_PTR: ptr <= 24'(merge({8'h00, ptr}, w_data, w_strb));
        default: ;
      endcase
    end
  end

  // run sequencer: busy for exactly the op's cycle count, state updates on the last
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state <= st_idle;
      cnt <= 3'h0;
    end
    else
    begin
      case (state)
        st_idle: if (start)
        begin
          state <= st_run;
          cnt <= CYC_ONE;
        end
        st_run: if (commit)
          state <= st_idle;
        else
          cnt <= cnt + 3'h1;
        default: state <= st_idle;
      endcase
    end
  end

  mbeu_mult u_mult (
    .i_ref_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_start((state == st_run) && (cnt == CYC_ONE)),
    .i_op(op),
    .i_rd(rd),
    .i_rr(rr),
    .o_product(mul_p),
    .o_carry(mul_c)
  );

  // compare subtraction; result is used for flags only
  always_comb
  begin
    diff = {1'b0, rd} - {1'b0, rr} - 9'((op == cmp_carry_op) & flags[FLG_C]);
    brw = (~rd & rr) | (rr & diff[7:0]) | (diff[7:0] & ~rd);
  end

  // decode: branch or skip condition, target, flag and register effects, cycle count
  always_comb
  begin
    next_pc = pc_inc;
    next_flags = flags;
    next_rd = rd_result;
    ret_addr = pc_inc;
    cycles = CYC_ONE;
    push = 1'b0;
    pop = 1'b0;
    is_branch = 1'b0;
    is_skip = 1'b0;
    cond = 1'b0;
    case (op)
      reg_test_op, reg_clear_op:
      begin
        next_rd = (op == reg_clear_op) ? 8'h00 : rd;
        next_flags[FLG_Z] = (next_rd == 8'h00);
        next_flags[FLG_N] = next_rd[7];
        next_flags[FLG_V] = 1'b0;
      end
      reg_all_ones_op: next_rd = ALL_ONES;
      mult_unsigned_op, mult_signed_op, mult_mixed_op,
      frac_mult_unsigned_op, frac_mult_signed_op, frac_mult_mixed_op:
      begin
        cycles = CYC_MULT;
        next_flags[FLG_Z] = (mul_p == 16'h0000);
        next_flags[FLG_C] = mul_c;
      end
      rel_jump_op, rel_call_op: next_pc = pc_inc + {{(PC_W-KOFF_W){koff[KOFF_W-1]}}, koff};
      ptr_jump_op, ptr_call_op: next_pc = PC_W'(ptr[PTR_EXT_LSB-1:0]);
      ext_ptr_jump_op, ext_ptr_call_op: next_pc = PC_W'(ptr);
      abs_jump_op, abs_call_op:
      begin
        next_pc = jaddr;
        ret_addr = pc + PC_W'(2); // two-word form returns past its address word
      end
      sub_return_op, irq_return_op:
      begin
        pop = 1'b1;
        cycles = CYC_RET;
        next_pc = stack_mem[sp - SP_W'(1)];
        if (op == irq_return_op)
          next_flags[FLG_I] = 1'b1;
      end
      cmp_reg_op, cmp_carry_op, cmp_imm_op:
      begin
        next_flags[FLG_Z] = (diff[7:0] == 8'h00) & ((op != cmp_carry_op) | flags[FLG_Z]);
        next_flags[FLG_N] = diff[7];
        next_flags[FLG_V] = (rd[7] & ~rr[7] & ~diff[7]) | (~rd[7] & rr[7] & diff[7]);
        next_flags[FLG_C] = brw[7];
        next_flags[FLG_H] = brw[3];
      end
      cmp_skip_eq_op: {is_skip, cond} = {1'b1, rd == rr};
      skip_regbit_clr_op: {is_skip, cond} = {1'b1, ~rr[src[SRC_BIT_LSB +: 3]]};
      skip_regbit_set_op: {is_skip, cond} = {1'b1, rr[src[SRC_BIT_LSB +: 3]]};
      skip_iobit_clr_op: {is_skip, cond} = {1'b1, ~src[SRC_IO_LSB + 32'(src[SRC_BIT_LSB +: 3])]};
      skip_iobit_set_op: {is_skip, cond} = {1'b1, src[SRC_IO_LSB + 32'(src[SRC_BIT_LSB +: 3])]};
      branch_flag_set_op: {is_branch, cond} = {1'b1, flags[src[SRC_BIT_LSB +: 3]]};
      branch_flag_clr_op: {is_branch, cond} = {1'b1, ~flags[src[SRC_BIT_LSB +: 3]]};
      branch_equal_op: {is_branch, cond} = {1'b1, flags[FLG_Z]};
      branch_not_equal_op: {is_branch, cond} = {1'b1, ~flags[FLG_Z]};
      branch_carry_set_op, branch_lower_op: {is_branch, cond} = {1'b1, flags[FLG_C]};
      branch_carry_clr_op, branch_same_higher_op: {is_branch, cond} = {1'b1, ~flags[FLG_C]};
      branch_minus_op: {is_branch, cond} = {1'b1, flags[FLG_N]};
      branch_plus_op: {is_branch, cond} = {1'b1, ~flags[FLG_N]};
      branch_ge_signed_op: {is_branch, cond} = {1'b1, ~(flags[FLG_N] ^ flags[FLG_V])};
      branch_lt_signed_op: {is_branch, cond} = {1'b1, flags[FLG_N] ^ flags[FLG_V]};
      branch_halfc_set_op: {is_branch, cond} = {1'b1, flags[FLG_H]};
      branch_halfc_clr_op: {is_branch, cond} = {1'b1, ~flags[FLG_H]};
      branch_tflag_set_op: {is_branch, cond} = {1'b1, flags[FLG_T]};
      branch_tflag_clr_op: {is_branch, cond} = {1'b1, ~flags[FLG_T]};
      default: ;
    endcase
    case (op)
      rel_jump_op, ptr_jump_op, ext_ptr_jump_op: cycles = CYC_JMP;
      abs_jump_op: cycles = CYC_ABS_JMP;
      rel_call_op, ptr_call_op, ext_ptr_call_op: {push, cycles} = {1'b1, CYC_CALL};
      abs_call_op: {push, cycles} = {1'b1, CYC_ABS_CALL};
      default: ;
    endcase
    // the skipped instruction may be one or two words long
    if (is_skip && cond)
    begin
      cycles = src[SRC_TWO_WORD] ? CYC_SKIP2 : CYC_SKIP1;
      next_pc = pc + (src[SRC_TWO_WORD] ? PC_W'(3) : PC_W'(2));
    end
    if (is_branch && cond)
    begin
      cycles = CYC_TAKEN;
      next_pc = pc_inc + {{(PC_W-BR_OFF_W){koff[BR_OFF_W-1]}}, koff[BR_OFF_W-1:0]};
    end
  end

  // program counter: software load when idle, otherwise the decoded target
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      pc <= '0;
    else if (commit)
      pc <= next_pc;
    else if (wr_fire && !O_BUSY && aw_addr == ADDR_PC)
      pc <= PC_W'(merge(32'(pc), w_data, w_strb));
  end

  // status flags and result registers
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      flags <= FLAGS_RST;
      rd_result <= 8'h00;
      r1r0 <= 16'h0000;
    end
    else if (commit)
    begin
      flags <= next_flags;
      rd_result <= next_rd;
      if (cycles == CYC_MULT && !is_skip && !is_branch && !push && op <= frac_mult_mixed_op)
        r1r0 <= mul_p;
    end
    else if (wr_fire && !O_BUSY && aw_addr == ADDR_FLAGS && w_strb[0])
      flags <= w_data[7:0];
  end

  // return stack; it wraps silently, software watches the depth in the sp register
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      sp <= '0;
    else if (commit && push)
      sp <= sp + SP_W'(1);
    else if (commit && pop)
      sp <= sp - SP_W'(1);
    else if (wr_fire && !O_BUSY && aw_addr == ADDR_SP && w_strb[0])
      sp <= w_data[SP_W-1:0];
  end

  // stack storage has no reset, so it maps onto plain ram
  always_ff @(posedge I_REF_CLK)
  begin
    if (commit && push)
      stack_mem[sp] <= ret_addr;
  end

  // read data mux
  always_comb
  begin
    rd_map = 1'b1;
    case (I_ARADDR)
      ADDR_CMD: rd_mux = 32'(op);
      ADDR_SRC: rd_mux = src;
      ADDR_KOFF: rd_mux = 32'(koff);
      ADDR_JADDR: rd_mux = 32'(jaddr);
      ADDR_PTR: rd_mux = 32'(ptr);
      ADDR_PC: rd_mux = 32'(pc);
      ADDR_FLAGS: rd_mux = 32'(flags);
      ADDR_RESULT: rd_mux = {8'h00, rd_result, r1r0};
      ADDR_STATUS: rd_mux = 32'(O_BUSY);
      ADDR_SP: rd_mux = 32'(sp);
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_map = 1'b0;
      end
    endcase
  end

  // read channel: one beat in flight, answer one cycle after address is taken
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= RESP_OKAY;
    end
    else if (I_ARVALID && O_ARREADY)
    begin
      O_RVALID <= 1'b1;
      O_RDATA <= rd_mux;
      O_RRESP <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (O_RVALID && I_RREADY)
      O_RVALID <= 1'b0;
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence busy2_s; O_BUSY [*2] ##1 !O_BUSY; endsequence
  sequence busy4_s; O_BUSY [*4] ##1 !O_BUSY; endsequence
  sequence busy5_s; O_BUSY [*5] ##1 !O_BUSY; endsequence

  mult_time_a: assert property (start && w_data[5:0] == 6'(mult_signed_op) |=> busy2_s)
    else $error("multiply did not take two cycles");
  frac_shift_a: assert property (commit && op == frac_mult_unsigned_op |=>
    r1r0 == 16'(({8'h00, $past(rd)} * {8'h00, $past(rr)}) << 1))
    else $error("fractional product not shifted");
  test_keep_a: assert property (commit && op == reg_test_op |=>
    rd_result == $past(rd) && !flags[FLG_V] && flags[FLG_N] == $past(rd[7]))
    else $error("register test altered value or flags wrong");
  clear_zero_a: assert property (commit && op == reg_clear_op |=> rd_result == 8'h00 && flags[FLG_Z])
    else $error("clear did not give zero");
  ones_flags_a: assert property (commit && op == reg_all_ones_op |=> rd_result == ALL_ONES && $stable(flags))
    else $error("set-all wrong or flags changed");
  rel_target_a: assert property (commit && op == rel_jump_op |=>
    pc == $past(pc) + PC_W'(1) + {{(PC_W-KOFF_W){$past(koff[KOFF_W-1])}}, $past(koff)})
    else $error("relative jump target wrong");
  call_time_a: assert property (start && w_data[5:0] == 6'(abs_call_op) |=> busy5_s)
    else $error("absolute call not five cycles");
  ptr_call_a: assert property (start && w_data[5:0] == 6'(ptr_call_op) |=> busy4_s)
    else $error("pointer call not four cycles");
  skip_eq_a: assert property (commit && op == cmp_skip_eq_op && rd == rr && !src[SRC_TWO_WORD]
    |=> pc == $past(pc) + PC_W'(2) && $stable(flags))
    else $error("equal compare did not skip one word");
  cmp_store_a: assert property (commit && op == cmp_reg_op |=> $stable(rd_result) &&
    flags[FLG_C] == $past(rd < rr))
    else $error("compare stored result or carry wrong");
  br_fall_a: assert property (commit && is_branch && !cond |=> pc == $past(pc_inc) && $past(cnt) == CYC_ONE)
    else $error("untaken branch moved or took two cycles");
  ge_signed_a: assert property (commit && op == branch_ge_signed_op &&
    (flags[FLG_N] ^ flags[FLG_V]) |=> pc == $past(pc_inc))
    else $error("signed ge taken with n xor v set");
  irq_return_op_flag_a: assert property (commit && op == irq_return_op |=> flags[FLG_I] &&
    $past(cnt) == CYC_RET && sp == $past(sp) - SP_W'(1))
    else $error("interrupt return wrong");
endmodule // mbeu_core

// ==== pkg/mbeu_pkg.sv ====
package mbeu_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_SRC = 8'h04;
  localparam logic [7:0] ADDR_KOFF = 8'h08;
  localparam logic [7:0] ADDR_JADDR = 8'h0c;
  localparam logic [7:0] ADDR_PTR = 8'h10;
  localparam logic [7:0] ADDR_PC = 8'h14;
  localparam logic [7:0] ADDR_FLAGS = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_SP = 8'h24;
  localparam int AXI_AW = 8;
  // operand register field positions
  localparam int SRC_RD_LSB = 0;
  localparam int SRC_RR_LSB = 8;
  localparam int SRC_BIT_LSB = 16;
  localparam int SRC_TWO_WORD = 19;
  localparam int SRC_IO_LSB = 24;
  localparam int KOFF_W = 12;
  localparam int BR_OFF_W = 7;
  localparam int PTR_EXT_LSB = 16;
  localparam int RES_RD_LSB = 16;
  // status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  // reset values and constants
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam int PC_WIDTH = 22;
  localparam int STACK_DEPTH_DEF = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // execution cycle counts
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_MULT = 3'h2;
  localparam logic [2:0] CYC_JMP = 3'h2;
  localparam logic [2:0] CYC_ABS_JMP = 3'h3;
  localparam logic [2:0] CYC_CALL = 3'h4;
  localparam logic [2:0] CYC_ABS_CALL = 3'h5;
  localparam logic [2:0] CYC_RET = 3'h5;
  localparam logic [2:0] CYC_TAKEN = 3'h2;
  localparam logic [2:0] CYC_SKIP1 = 3'h2;
  localparam logic [2:0] CYC_SKIP2 = 3'h3;
  // operation codes written to the command register
  typedef enum logic [5:0] {
    reg_test_op = 6'h00, reg_clear_op = 6'h01, reg_all_ones_op = 6'h02,
    mult_unsigned_op = 6'h03, mult_signed_op = 6'h04, mult_mixed_op = 6'h05,
    frac_mult_unsigned_op = 6'h06, frac_mult_signed_op = 6'h07, frac_mult_mixed_op = 6'h08,
    rel_jump_op = 6'h09, ptr_jump_op = 6'h0a, ext_ptr_jump_op = 6'h0b, abs_jump_op = 6'h0c,
    rel_call_op = 6'h0d, ptr_call_op = 6'h0e, ext_ptr_call_op = 6'h0f, abs_call_op = 6'h10,
    sub_return_op = 6'h11, irq_return_op = 6'h12, cmp_skip_eq_op = 6'h13,
    cmp_reg_op = 6'h14, cmp_carry_op = 6'h15, cmp_imm_op = 6'h16,
    skip_regbit_clr_op = 6'h17, skip_regbit_set_op = 6'h18,
    skip_iobit_clr_op = 6'h19, skip_iobit_set_op = 6'h1a,
    branch_flag_set_op = 6'h1b, branch_flag_clr_op = 6'h1c,
    branch_equal_op = 6'h1d, branch_not_equal_op = 6'h1e,
    branch_carry_set_op = 6'h1f, branch_carry_clr_op = 6'h20,
    branch_same_higher_op = 6'h21, branch_lower_op = 6'h22,
    branch_minus_op = 6'h23, branch_plus_op = 6'h24,
    branch_ge_signed_op = 6'h25, branch_lt_signed_op = 6'h26,
    branch_halfc_set_op = 6'h27, branch_halfc_clr_op = 6'h28,
    branch_tflag_set_op = 6'h29, branch_tflag_clr_op = 6'h2a
  } mbeu_op_t;
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run = 2'b10
  } mbeu_state_t;
endpackage

// ==== core/mbeu_mult.sv ====
`timescale 1ns/1ns
module mbeu_mult
  import mbeu_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // request
  input wire logic i_start,
  input wire mbeu_op_t i_op,
  input wire logic [7:0] i_rd,
  input wire logic [7:0] i_rr,
  // result
  output logic [15:0] o_product,
  output logic o_carry
);
  logic sign_d;
  logic sign_r;
  logic frac;
  logic signed [17:0] raw;

  // operand signedness and fractional shift per variant
  always_comb
  begin
    sign_d = (i_op == mult_signed_op) || (i_op == mult_mixed_op) ||
             (i_op == frac_mult_signed_op) || (i_op == frac_mult_mixed_op);
    sign_r = (i_op == mult_signed_op) || (i_op == frac_mult_signed_op);
    frac = (i_op == frac_mult_unsigned_op) || (i_op == frac_mult_signed_op) ||
           (i_op == frac_mult_mixed_op);
    raw = $signed({sign_d & i_rd[7], i_rd}) * $signed({sign_r & i_rr[7], i_rr});
  end

  // one register stage; carry is taken before the fractional shift
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_product <= 16'h0000;
      o_carry <= 1'b0;
    end
    else if (i_start)
    begin
      o_product <= frac ? {raw[14:0], 1'b0} : raw[15:0];
      o_carry <= raw[15];
    end
  end
endmodule // mbeu_mult

// ==== bench/multiply_branch_exec_unit_tb.sv ====
`timescale 1ns/1ns
module multiply_branch_exec_unit_tb;
  import mbeu_pkg::*;
  logic I_REF_CLK, I_RST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [7:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA, ep;
  logic [3:0] I_WSTRB;
  wire logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_BUSY;
  wire logic [1:0] O_BRESP, O_RRESP;
  wire logic [31:0] O_RDATA;
  int n_errors, checks_done, busy_cnt;
  logic [31:0] rq[$];
  // operation tables with the products and branch outcomes worked out by hand
  mbeu_op_t mo[6] = '{mult_unsigned_op, mult_signed_op, mult_mixed_op, frac_mult_unsigned_op,
    frac_mult_signed_op, frac_mult_mixed_op};
  logic [15:0] mp[6] = '{16'hfe01, 16'h0001, 16'hff01, 16'hfc02, 16'h0002, 16'hfe02};
  mbeu_op_t bo[16] = '{branch_flag_set_op, branch_flag_clr_op, branch_equal_op, branch_not_equal_op,
    branch_carry_set_op, branch_carry_clr_op, branch_same_higher_op, branch_lower_op, branch_minus_op,
    branch_plus_op, branch_ge_signed_op, branch_lt_signed_op, branch_halfc_set_op, branch_halfc_clr_op,
    branch_tflag_set_op, branch_tflag_clr_op};
  logic [7:0] bf[16] = '{8'h40, 8'h40, 8'h02, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01, 8'h04, 8'h04, 8'h0c,
    8'h04, 8'h00, 8'h20, 8'h40, 8'h00};
  logic [15:0] bt = 16'hcda5;
  mbeu_op_t co[4] = '{rel_call_op, ptr_call_op, ext_ptr_call_op, abs_call_op};
  logic [31:0] ct[4] = '{32'h0, 32'h1234, 32'h51234, 32'h2222};

  mbeu_core dut (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
    .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .O_BUSY(O_BUSY));

  // 250 mhz clock
  initial
  begin
    I_REF_CLK = 1'h0;
    forever #2 I_REF_CLK = ~I_REF_CLK;
  end

  // edges that see busy high give the execution length
  always @(posedge I_REF_CLK)
    if (O_BUSY === 1'h1) busy_cnt <= busy_cnt + 1;

  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask

  // ready is sampled mid-cycle, so the decision matches what the next edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw = 1'h0, w = 1'h0, b = 1'h0;
    @(posedge I_REF_CLK);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'h1;
    I_WVALID <= 1'h1;
    I_BREADY <= 1'h1;
    for (int n = 0; n < 40 && !b; n++)
    begin
      @(negedge I_REF_CLK);
      b = aw && w && O_BVALID === 1'h1;
      if (b) chk("bresp", {30'h0, O_BRESP}, {30'h0, er});
      aw = aw || O_AWREADY === 1'h1;
      w = w || O_WREADY === 1'h1;
      @(posedge I_REF_CLK);
      if (aw) I_AWVALID <= 1'h0;
      if (w) I_WVALID <= 1'h0;
      if (b) I_BREADY <= 1'h0;
    end
    if (!b)
    begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ar = 1'h0, g = 1'h0;
    @(posedge I_REF_CLK);
    I_ARADDR <= a;
    I_ARVALID <= 1'h1;
    I_RREADY <= 1'h1;
    for (int n = 0; n < 40 && !g; n++)
    begin
      @(negedge I_REF_CLK);
      g = ar && O_RVALID === 1'h1;
      if (g) d = O_RDATA;
      if (g) chk("rresp", {30'h0, O_RRESP}, {30'h0, er});
      ar = ar || O_ARREADY === 1'h1;
      @(posedge I_REF_CLK);
      if (ar) I_ARVALID <= 1'h0;
      if (g) I_RREADY <= 1'h0;
    end
    if (!g)
    begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic rck(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    rd(a, d, RESP_OKAY);
    chk($sformatf("reg %h", a), e & m, d & m);
  endtask

  // start an operation, optionally try a pc write while busy, then poll status
  task automatic op(input mbeu_op_t c, input int cyc, input logic poke);
    logic [31:0] d = 32'h1;
    int c0;
    c0 = busy_cnt;
    wr(ADDR_CMD, {26'h0, c}, RESP_OKAY);
    if (poke) wr(ADDR_PC, 32'h0abc, RESP_OKAY);
    for (int n = 0; n < 20 && d[0] !== 1'h0; n++) rd(ADDR_STATUS, d, RESP_OKAY);
    chk("status", 32'h0, d);
    if (d !== 32'h0) complete_run();
    chk("cycles", cyc, busy_cnt - c0);
    rck(ADDR_PC, ep, 32'hffffffff);
  endtask

  initial
  begin
    {I_RST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_AWADDR, I_ARADDR, I_WDATA} = '0;
    I_WSTRB = 4'hf;
    ep = 32'h0;
    repeat (2) @(posedge I_REF_CLK);
    I_RST_N <= 1'h1;
    rck(ADDR_PC, 32'h0, 32'hffffffff);
    rck(ADDR_FLAGS, {24'h0, FLAGS_RST}, 32'hff);
    rd(8'h3c, ep, RESP_SLVERR);
    chk("unmapped", 32'h0, ep);
    ep = 32'h0;
    wr(ADDR_RESULT, 32'h1, RESP_SLVERR);
    wr(ADDR_SRC, 32'h0000ffff, RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      ep++;
      op(mo[i], 2, 1'h0);
      rck(ADDR_RESULT, {16'h0, mp[i]}, 32'hffff);
      rck(ADDR_FLAGS, {31'h0, mp[i][15]}, 32'hff);
    end
    wr(ADDR_SRC, 32'h00000080, RESP_OKAY);
    ep++;
    op(reg_test_op, 1, 1'h0);
    rck(ADDR_RESULT, 32'h800000, 32'hff0000);
    rck(ADDR_FLAGS, 32'h05, 32'hff);
    ep++;
    op(reg_clear_op, 1, 1'h0);
    rck(ADDR_FLAGS, 32'h03, 32'hff);
    ep++;
    op(reg_all_ones_op, 1, 1'h0);
    rck(ADDR_RESULT, {8'h0, ALL_ONES, 16'h0}, 32'hff0000);
    rck(ADDR_FLAGS, 32'h03, 32'hff);
    wr(ADDR_SRC, 32'h00001010, RESP_OKAY);
    ep++;
    op(cmp_imm_op, 1, 1'h0);
    rck(ADDR_FLAGS, 32'h02, 32'hff);
    ep += 2;
    op(cmp_skip_eq_op, 2, 1'h0);
    wr(ADDR_SRC, 32'h00002010, RESP_OKAY);
    ep++;
    op(cmp_reg_op, 1, 1'h0);
    rck(ADDR_FLAGS, 32'h05, 32'hff);
    wr(ADDR_SRC, 32'h00081010, RESP_OKAY);
    ep += 3;
    op(cmp_skip_eq_op, 3, 1'h0);
    wr(ADDR_SRC, 32'h00078080, RESP_OKAY);
    ep += 2;
    op(skip_regbit_set_op, 2, 1'h0);
    wr(ADDR_SRC, 32'h01000000, RESP_OKAY);
    ep++;
    op(skip_iobit_clr_op, 1, 1'h0);
    rck(ADDR_FLAGS, 32'h05, 32'hff);
    wr(ADDR_SRC, 32'h00060000, RESP_OKAY);
    wr(ADDR_KOFF, 32'h3, RESP_OKAY);
    for (int i = 0; i < 16; i++)
    begin
      wr(ADDR_FLAGS, {24'h0, bf[i]}, RESP_OKAY);
      ep += bt[i] ? 4 : 1;
      op(bo[i], bt[i] ? 2 : 1, 1'h0);
      rck(ADDR_FLAGS, {24'h0, bf[i]}, 32'hff);
    end
    wr(ADDR_FLAGS, 32'h08, RESP_OKAY);
    ep++;
    op(branch_ge_signed_op, 1, 1'h0);
    wr(ADDR_KOFF, 32'hffc, RESP_OKAY);
    wr(ADDR_PTR, 32'h00051234, RESP_OKAY);
    wr(ADDR_JADDR, 32'h2222, RESP_OKAY);
    ep -= 3;
    op(rel_jump_op, 2, 1'h0);
    ep = 32'h1234;
    op(ptr_jump_op, 2, 1'h0);
    ep = 32'h51234;
    op(ext_ptr_jump_op, 2, 1'h0);
    ep = 32'h2222;
    op(abs_jump_op, 3, 1'h0);
    for (int i = 0; i < 4; i++)
    begin
      rq.push_back(ep + ((i == 3) ? 2 : 1));
      ep = (i == 0) ? ep - 3 : ct[i];
      op(co[i], (i == 3) ? 5 : 4, i == 3);
    end
    for (int i = 0; i < 4; i++)
    begin
      ep = rq.pop_back();
      op((i == 0) ? irq_return_op : sub_return_op, 5, 1'h0);
    end
    rck(ADDR_FLAGS, 32'h80, 32'h80);
    complete_run();
  end
endmodule // multiply_branch_exec_unit_tb
